/* File: rgbs_regs.svh */
// register map, field positions, timing figures and the behaviour list of the rgb sequencer
// Behaviour
// [RQ1] Bit 4 of the second audio control register turns averaging of the audio level on or off.
// [RQ2] Bits 1-0 of that register pick the response speed (00 fastest to 11 slow) and bits 3-2 the filtering mode.
// [RQ3] Step word A holds red in bits 7-5, green in 4-2 and execution time bits 3-2 in 1-0, 197 ms to 3146 ms.
// [RQ4] Step word B holds execution time bits 1-0 in 7-6, blue in 5-3 and a ramp code in 2-0, 0 ms to 3539 ms.
// [RQ5] With the curve bit at 0 a colour code maps to 0, 7, 14, 21, 32, 46, 71 or 100 percent.
// [RQ6] With the curve bit at 1 a colour code maps to 0, 1, 2, 4, 10, 21, 46 or 100 percent.
// [RQ7] Any write to address 60H resets all logic and registers, and that address reads as zero.
// [RQ8] Setting the run bit starts the pattern at the first step, clearing it stops the generator.
// [RQ9] With the repeat bit set the steps loop until stopped, otherwise the pattern runs once.
// [RQ10] The filter-domain bit selects amplitude mode at 0 and frequency mode at 1.
// [RQ11] Each step ramps every colour from its old level over the ramp time, holds, then advances.
`ifndef RGBS_REGS_SVH
`define RGBS_REGS_SVH
// addresses
`define RGBS_ADDR_PATTERN_CTRL 8'h11
`define RGBS_ADDR_AUDIO_ONE 8'h2A
`define RGBS_ADDR_AUDIO_TWO 8'h2B
`define RGBS_ADDR_STEP_A_BASE 8'h50
`define RGBS_ADDR_STEP_B_BASE 8'h58
`define RGBS_ADDR_SOFT_RESET 8'h60
`define RGBS_ADDR_STATUS 8'h61
// reset values
`define RGBS_RST_AUDIO_ONE 8'h03
`define RGBS_RST_ZERO 8'h00
// field positions
`define RGBS_AUD_AVG_BIT 4
`define RGBS_AUD_MODE_HI 3
`define RGBS_AUD_MODE_LO 2
`define RGBS_AUD_SPEED_HI 1
`define RGBS_AUD_SPEED_LO 0
`define RGBS_AUD1_DOMAIN_BIT 4
`define RGBS_PAT_RUN_BIT 2
`define RGBS_PAT_LOOP_BIT 1
`define RGBS_PAT_CURVE_BIT 0
`define RGBS_A_RED_HI 7
`define RGBS_A_RED_LO 5
`define RGBS_A_GREEN_HI 4
`define RGBS_A_GREEN_LO 2
`define RGBS_A_CET_HI 1
`define RGBS_A_CET_LO 0
`define RGBS_B_CET_HI 7
`define RGBS_B_CET_LO 6
`define RGBS_B_BLUE_HI 5
`define RGBS_B_BLUE_LO 3
`define RGBS_B_RAMP_HI 2
`define RGBS_B_RAMP_LO 0
// timing: clock period and one millisecond in ns, execution step in tenths of a ms
`define RGBS_CLK_NS 40
`define RGBS_MS_NS 1000000
`define RGBS_CET_STEP_TENTH_MS 1966
`define RGBS_TENTHS 10
`define RGBS_ROUND_HALF 5
// ramp times in ms, index = code
`define RGBS_RAMP_MS_LIST {12'd3539, 12'd1770, 12'd885, 12'd442, 12'd221, 12'd110, 12'd55, 12'd0}
// current curves in percent, index = colour code
`define RGBS_CURVE_LIN {7'd100, 7'd71, 7'd46, 7'd32, 7'd21, 7'd14, 7'd7, 7'd0}
`define RGBS_CURVE_LOG {7'd100, 7'd46, 7'd21, 7'd10, 7'd4, 7'd2, 7'd1, 7'd0}
`endif

/* File: rgbs_pkg.sv */
// types shared by the rgb sequencer
package rgbs_pkg;
  typedef enum logic [0:0] {RGBS_IDLE, RGBS_RUN} rgbs_phase_t;

  // one colour triple, levels in percent
  typedef struct packed {
    logic [6:0] red;
    logic [6:0] green;
    logic [6:0] blue;
  } rgbs_rgb_t;

  // audio settings presented to the audio front end
  typedef struct packed {
    logic avg_enable;
    logic [1:0] filter_mode;
    logic [1:0] speed;
    logic freq_domain;
  } rgbs_audio_t;
endpackage

/* File: rgbs_sequencer.sv */
// command-driven rgb pattern sequencer with audio-sync control registers
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "rgbs_regs.svh"

module rgbs_sequencer
  import rgbs_pkg::*;
#(
  parameter int STEPS = 8,
  parameter int MS_CYCLES = `RGBS_MS_NS / `RGBS_CLK_NS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // colour levels and status
  output rgbs_rgb_t led_level,
  output logic seq_active,
  output logic [2:0] seq_step,
  // audio settings
  output rgbs_audio_t audio_cfg
);

  // elaboration checks: the step table is fixed and the divider is sixteen bits wide
  if (STEPS != 8) begin
    $error("step table is fixed at eight entries");
  end
  if (MS_CYCLES < 1 || MS_CYCLES > 65535) begin
    $error("millisecond divider out of range");
  end

  // every register of the block in one word; next_s is its combinational copy
  typedef struct packed {
    logic [7:0] audio_one;
    logic [4:0] audio_two;
    logic [2:0] pat_ctrl;
    logic [7:0][7:0] step_a;
    logic [7:0][7:0] step_b;
    rgbs_phase_t phase;
    logic [2:0] step;
    logic [15:0] div;
    logic [11:0] ms;
    rgbs_rgb_t prev;
    rgbs_rgb_t level;
    logic [7:0] rdata;
    logic run_q;
  } rgbs_state_t;

  localparam rgbs_state_t RST = '{
    audio_one: `RGBS_RST_AUDIO_ONE, audio_two: '0, pat_ctrl: '0,
    step_a: '0, step_b: '0, phase: RGBS_IDLE, step: '0, div: '0, ms: '0,
    prev: '0, level: '0, rdata: '0, run_q: 1'b0};

  // tables hold code 0 in their lowest bits, so code times entry width indexes them
  localparam logic [95:0] RAMP_MS = `RGBS_RAMP_MS_LIST;
  localparam logic [55:0] CURVE_LIN = `RGBS_CURVE_LIN;
  localparam logic [55:0] CURVE_LOG = `RGBS_CURVE_LOG;
  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  rgbs_state_t s;
  rgbs_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // colour code to percent on the selected curve
  function automatic logic [6:0] pct(input logic [2:0] code, input logic curve);
    pct = curve ? CURVE_LOG[code*7 +: 7] : CURVE_LIN[code*7 +: 7]; // [RQ5] [RQ6]
  endfunction

  // linear blend from a to b at elapsed ms out of span ms
  // int arithmetic: the largest product, 100 x 4095, cannot overflow
  function automatic logic [6:0] blend(input logic [6:0] a, input logic [6:0] b,
                                       input logic [11:0] el, input logic [11:0] span);
    int d;
    d = 0;
    if (el >= span) begin
      blend = b;
    end else begin
      d = (int'(b) - int'(a)) * int'(el) / int'(span);
      blend = 7'(int'(a) + d);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode of the current step

  logic [7:0] cur_a;
  logic [7:0] cur_b;
  logic [3:0] cet_code;
  logic [11:0] cet_ms;
  logic [2:0] ramp_code;
  logic [11:0] ramp_ms;
  logic curve;
  rgbs_rgb_t target;

  always_comb begin
    cur_a = s.step_a[s.step];
    cur_b = s.step_b[s.step];
    // execution time code is split over both words
    cet_code = {cur_a[`RGBS_A_CET_HI:`RGBS_A_CET_LO], cur_b[`RGBS_B_CET_HI:`RGBS_B_CET_LO]}; // [RQ3] [RQ4]
    // 196.6 ms steps rounded to whole ms, 0000 gives 197
    cet_ms = 12'(((int'(cet_code) + 1) * `RGBS_CET_STEP_TENTH_MS + `RGBS_ROUND_HALF)
                 / `RGBS_TENTHS); // [RQ3]
    ramp_code = cur_b[`RGBS_B_RAMP_HI:`RGBS_B_RAMP_LO]; // [RQ4]
    ramp_ms = RAMP_MS[ramp_code*12 +: 12]; // [RQ4]
    curve = s.pat_ctrl[`RGBS_PAT_CURVE_BIT];
    target.red = pct(cur_a[`RGBS_A_RED_HI:`RGBS_A_RED_LO], curve); // [RQ3]
    target.green = pct(cur_a[`RGBS_A_GREEN_HI:`RGBS_A_GREEN_LO], curve); // [RQ3]
    target.blue = pct(cur_b[`RGBS_B_BLUE_HI:`RGBS_B_BLUE_LO], curve); // [RQ4]
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic step_done;
  logic run_bit;

  always_comb begin
    next_s = s;
    run_bit = s.pat_ctrl[`RGBS_PAT_RUN_BIT];
    next_s.run_q = run_bit;
    next_s.rdata = '0;
    // the step ends once both its execution time and its ramp have elapsed
    step_done = (s.ms >= cet_ms) && (s.ms >= ramp_ms);

    // sequencer
    unique case (s.phase)
      RGBS_IDLE: begin
        next_s.div = '0;
        next_s.ms = '0;
        // a cleared run bit darkens the outputs, also after a finished single pass
        if (!run_bit) begin
          next_s.level = '0; // [RQ8]
        end
        if (run_bit && !s.run_q) begin
          next_s.phase = RGBS_RUN; // [RQ8]
          next_s.step = '0; // [RQ8]
          next_s.prev = s.level;
        end
      end
      RGBS_RUN: begin
        // level follows the ramp, then holds the target
        next_s.level.red = blend(s.prev.red, target.red, s.ms, ramp_ms); // [RQ11]
        next_s.level.green = blend(s.prev.green, target.green, s.ms, ramp_ms); // [RQ11]
        next_s.level.blue = blend(s.prev.blue, target.blue, s.ms, ramp_ms); // [RQ11]
        if (s.div == MS_LAST) begin
          next_s.div = '0;
          if (!step_done) next_s.ms = s.ms + 12'd1;
        end else begin
          next_s.div = s.div + 16'd1;
        end
        if (!run_bit) begin
          next_s.phase = RGBS_IDLE; // [RQ8]
          next_s.level = '0; // [RQ8]
        end else if (step_done) begin
          next_s.level = target;
          next_s.prev = target; // [RQ11]
          next_s.ms = '0;
          next_s.div = '0;
          if (s.step == 3'(STEPS - 1)) begin
            next_s.step = '0;
            // single pass leaves the last colour lit and the generator stopped
            if (!s.pat_ctrl[`RGBS_PAT_LOOP_BIT]) next_s.phase = RGBS_IDLE; // [RQ9]
          end else begin
            next_s.step = s.step + 3'd1; // [RQ11]
          end
        end
      end
    endcase

    // register reads, answer in the next cycle
    if (reg_rd) begin
      if (reg_addr == `RGBS_ADDR_PATTERN_CTRL) next_s.rdata = 8'(s.pat_ctrl);
      else if (reg_addr == `RGBS_ADDR_AUDIO_ONE) next_s.rdata = s.audio_one;
      else if (reg_addr == `RGBS_ADDR_AUDIO_TWO) next_s.rdata = 8'(s.audio_two);
      else if (reg_addr == `RGBS_ADDR_STATUS) next_s.rdata = {4'h0, s.step, s.phase == RGBS_RUN};
      else if (reg_addr[7:3] == `RGBS_ADDR_STEP_A_BASE >> 3) next_s.rdata = s.step_a[reg_addr[2:0]];
      else if (reg_addr[7:3] == `RGBS_ADDR_STEP_B_BASE >> 3) next_s.rdata = s.step_b[reg_addr[2:0]];
      // soft reset address and unmapped addresses read zero
    end

    // register writes
    // upper bits of the control and audio-two words are not stored and read as zero
    if (reg_wr) begin
      if (reg_addr == `RGBS_ADDR_PATTERN_CTRL) next_s.pat_ctrl = reg_wdata[2:0];
      if (reg_addr == `RGBS_ADDR_AUDIO_ONE) next_s.audio_one = reg_wdata;
      if (reg_addr == `RGBS_ADDR_AUDIO_TWO) next_s.audio_two = reg_wdata[4:0]; // [RQ1] [RQ2]
      if (reg_addr[7:3] == `RGBS_ADDR_STEP_A_BASE >> 3) next_s.step_a[reg_addr[2:0]] = reg_wdata;
      if (reg_addr[7:3] == `RGBS_ADDR_STEP_B_BASE >> 3) next_s.step_b[reg_addr[2:0]] = reg_wdata;
      // any data written here restores every register and the sequencer
      if (reg_addr == `RGBS_ADDR_SOFT_RESET) next_s = RST; // [RQ7]
    end
  end

  // all state in one register
  // the reset value is a constant, so the asynchronous branch has no feedback path
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= RST;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata = s.rdata;
  assign led_level = s.level;
  assign seq_active = (s.phase == RGBS_RUN);
  assign seq_step = s.step;
  assign audio_cfg.avg_enable = s.audio_two[`RGBS_AUD_AVG_BIT]; // [RQ1]
  assign audio_cfg.filter_mode = s.audio_two[`RGBS_AUD_MODE_HI:`RGBS_AUD_MODE_LO]; // [RQ2]
  assign audio_cfg.speed = s.audio_two[`RGBS_AUD_SPEED_HI:`RGBS_AUD_SPEED_LO]; // [RQ2]
  assign audio_cfg.freq_domain = s.audio_one[`RGBS_AUD1_DOMAIN_BIT]; // [RQ10]

endmodule

/* File: rgbs_seq_props.sv */
// port checker for the rgb sequencer
`timescale 1ns/1ps
module rgbs_seq_props
  import rgbs_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // outputs
  input wire rgbs_rgb_t led_level,
  input wire logic seq_active,
  input wire logic [2:0] seq_step,
  input wire rgbs_audio_t audio_cfg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  // write data of the previous cycle, since $past takes whole signals only
  logic [7:0] prev_wd;
  always_ff @(posedge core_clk) begin
    prev_wd <= reg_wdata;
  end
  avg_follow_a: assert property (
    reg_wr && reg_addr == 8'h2B |=> audio_cfg.avg_enable == prev_wd[4])
    else $error("averaging enable not taken from write");
  speed_follow_a: assert property (reg_wr && reg_addr == 8'h2B |=>
    {audio_cfg.filter_mode, audio_cfg.speed} == prev_wd[3:0]) else $error("speed or mode wrong");
  domain_follow_a: assert property (
    reg_wr && reg_addr == 8'h2A |=> audio_cfg.freq_domain == prev_wd[4])
    else $error("domain bit not taken from write");
  reset_read_a: assert property (reg_rd && reg_addr == 8'h60 |=> reg_rdata == 8'h00)
    else $error("reset register read not zero");
  soft_clear_a: assert property (reg_wr && reg_addr == 8'h60 |-> ##2
    !seq_active && seq_step == 3'h0 && led_level == '0 && audio_cfg == '0)
    else $error("soft reset missed");
  stop_write_a: assert property (
    reg_wr && reg_addr == 8'h11 && !reg_wdata[2] |-> ##2 !seq_active && led_level == '0)
    else $error("clearing run did not stop");
  start_step_a: assert property ($rose(seq_active) |-> seq_step == 3'h0)
    else $error("run did not begin at first step");
  step_order_a: assert property (
    seq_active && $past(seq_active) && seq_step != $past(seq_step) |->
    seq_step == $past(seq_step) + 3'h1) else $error("step skipped");
  level_cap_a: assert property (
    led_level.red <= 7'h64 && led_level.green <= 7'h64 && led_level.blue <= 7'h64)
    else $error("level above full scale");
  cover property ($rose(seq_active));
  cover property (seq_active && seq_step == 3'h7 ##1 seq_step == 3'h0);
  cover property (reg_wr && reg_addr == 8'h60);
endmodule

/* File: tb.sv */
// self-checking bench for the rgb sequencer
`timescale 1ns/1ps
module tb;
  import rgbs_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  rgbs_rgb_t led_level;
  logic seq_active;
  logic [2:0] seq_step;
  rgbs_audio_t audio_cfg;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [2:0] rc [8];
  logic [2:0] gc [8];
  logic [2:0] bc [8];
  // two cycles per ms keeps the eight-step pattern short
  rgbs_sequencer #(.MS_CYCLES(2)) u_dut (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .led_level, .seq_active, .seq_step, .audio_cfg);
  initial forever #20 core_clk = ~core_clk;
  // watchdog: the pattern runs take about 28300 cycles, the ceiling leaves margin
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", 32'(reg_rdata), 32'(e));
  endtask
  function automatic logic [6:0] pct(input logic lg, input logic [2:0] c);
    logic [6:0] lin [8] = '{7'h00, 7'h07, 7'h0E, 7'h15, 7'h20, 7'h2E, 7'h47, 7'h64};
    logic [6:0] lgc [8] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h0A, 7'h15, 7'h2E, 7'h64};
    return lg ? lgc[c] : lin[c];
  endfunction
  function automatic logic [31:0] tgt(input logic lg, input int i);
    return 32'({pct(lg, rc[i]), pct(lg, gc[i]), pct(lg, bc[i])});
  endfunction
  // step i runs with execution code i; levels sampled 100 cycles into each step, length measured
  task automatic run_pat(input logic lg);
    int t0;
    for (int i = 0; i < 8; i++) begin
      while (!(seq_active && seq_step == i[2:0])) @(posedge core_clk);
      t0 = cyc;
      repeat (100) @(posedge core_clk);
      chk("led_level", 32'(led_level), tgt(lg, i));
      while (seq_active && seq_step == i[2:0]) @(posedge core_clk);
      t0 = cyc - t0 - ((i + 1) * 1966 + 5) / 10 * 2;
      chk("step_len", 32'(t0 >= 0 && t0 < 8), 32'h1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    void'($urandom(32'h6C67));
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(8'h2A, 8'h03);
    rd(8'h2B, 8'h00);
    rd(8'h7F, 8'h00);
    // every speed and mode code, random upper bits
    for (int k = 0; k < 16; k++) begin
      d = (8'($urandom) & 8'hF0) | 8'(k);
      wr(8'h2B, d);
      rd(8'h2B, d & 8'h1F);
      chk("avg", 32'(audio_cfg.avg_enable), 32'(d[4]));
      chk("mode", 32'({audio_cfg.filter_mode, audio_cfg.speed}), 32'(d[3:0]));
      wr(8'h2A, d);
      // the write lands at the edge the task returns on, so look once it has settled
      #1 chk("domain", 32'(audio_cfg.freq_domain), 32'(d[4]));
    end
    for (int i = 0; i < 8; i++) begin
      {rc[i], gc[i], bc[i]} = 9'($urandom);
      wr(8'h50 + 8'(i), {rc[i], gc[i], 2'(i >> 2)});
      wr(8'h58 + 8'(i), {2'(i), bc[i], 3'h0});
      rd(8'h58 + 8'(i), {2'(i), bc[i], 3'h0});
    end
    wr(8'h11, 8'h04);
    run_pat(1'b0);
    chk("once", 32'({seq_active, 21'(led_level)}), tgt(1'b0, 7));
    wr(8'h11, 8'h00);
    wr(8'h11, 8'h07);
    run_pat(1'b1);
    chk("loop", 32'({seq_active, seq_step}), 32'h8);
    wr(8'h11, 8'h03);
    repeat (2) @(posedge core_clk);
    chk("stop", 32'({seq_active, 21'(led_level)}), 32'h0);
    // soft reset in mid-run must restore every register to its reset value
    wr(8'h11, 8'h05);
    repeat (50) @(posedge core_clk);
    wr(8'h60, 8'($urandom));
    repeat (2) @(posedge core_clk);
    chk("soft", 32'({seq_active, 21'(led_level)}), 32'h0);
    rd(8'h2A, 8'h03);
    rd(8'h50, 8'h00);
    rd(8'h11, 8'h00);
    rd(8'h60, 8'h00);
    // first step ramps to full red over 55 ms: partway up mid-ramp, full at step end
    wr(8'h50, 8'hE0);
    wr(8'h58, 8'h01);
    wr(8'h11, 8'h04);
    while (!seq_active) @(posedge core_clk);
    repeat (55) @(posedge core_clk);
    chk("ramp_mid", 32'(led_level.red > 7'h1E && led_level.red < 7'h46), 32'h1);
    while (seq_active && seq_step == 3'h0) @(posedge core_clk);
    chk("ramp_end", 32'(led_level), 32'({7'h64, 7'h00, 7'h00}));
    test_done();
  end
endmodule
bind rgbs_sequencer rgbs_seq_props u_props (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .led_level, .seq_active, .seq_step, .audio_cfg);
